// [core/qwp_host.sv]
// Purpose: Controller end: buffers wiper writes, drives the link
// Assumes: clk_sys at 25 MHz; link clock made here by a divider
// Notes:   The link clock stands still outside frames, reset included
module qwp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];   // Storage
	logic [AW:0]  wr_q;          // Write pointer with wrap bit
	logic [AW:0]  rd_q;          // Read pointer with wrap bit
	logic         full;          // No room left
	logic         empty;         // Nothing stored

	assign full      = (wr_q[AW] != rd_q[AW]) &&
		(wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	// Write port
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wr_q <= '0;
		end else if (in_valid && !full) begin
			mem[wr_q[AW-1:0]] <= in_data;
			wr_q              <= wr_q + 1'b1;
		end
	end

	// Read port
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_q <= '0;
		end else if (out_ready && !empty) begin
			rd_q <= rd_q + 1'b1;
		end
	end
endmodule

module qwp_host (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// Write words in: channel in bits 7:6, position in 5:0
	input  wire logic              wr_valid,
	output logic                   wr_ready,
	input  wire qwp_pkg::qwp_word_t wr_data,
	// Read request and read-back words
	input  wire logic              rd_req,
	output logic                   rd_valid,
	output qwp_pkg::qwp_word_t     rd_data,
	output logic                   busy,
	// Link to the device
	qwp_if.host                    link
);
	import qwp_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_SETUP = 3'b001,
		H_LOW   = 3'b010,
		H_HIGH  = 3'b011,
		H_CLOSE = 3'b100
	} qwp_hstate_e;

	qwp_hstate_e state_q;        // Link sequencer
	logic [2:0]  div_q;          // Half-period counter
	logic        tick;           // End of a half period
	logic        sclk_q;         // Link clock
	logic        frame_q;        // Transfer window
	logic        dir_q;          // Direction, high reads
	logic [7:0]  sh_q;           // Outgoing word, MSB on the pin
	logic [5:0]  bit_q;          // Bits clocked in this frame
	logic [7:0]  rsh_q;          // Incoming read bits
	logic        rd_pend_q;      // Read asked for, read frame not yet started
	logic        dout_m_q;       // First synchroniser stage
	logic        dout_s_q;       // Second synchroniser stage
	logic        f_valid;        // Buffer has a word
	logic        f_pop;          // Take one word from the buffer
	qwp_word_t   f_data;         // Word at buffer head
	logic        more;           // Another write word fits this frame

	// Write buffer; the sequencer drains it only at frame setup and between words,
	// so a slow link really fills it and stalls the user
	qwp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) i_qwp_fifo (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);

	assign tick = (div_q == 3'(SCLK_HALF - 1));
	assign more = f_valid && (bit_q[5:3] < 3'(WORDS_MAX - 1));
	assign f_pop = tick && !dir_q &&
		((state_q == H_SETUP) ||
		 (state_q == H_HIGH && bit_q[2:0] == LAST_BIT && more));
	assign busy = (state_q != H_IDLE) || rd_pend_q;

	// Link pins from flip-flops, choice pin tied low
	assign link.sclk                 = sclk_q;
	assign link.frame                = frame_q;
	assign link.din                  = sh_q[7];
	assign link.dir                  = dir_q;
	assign link.interface_choice_pin = 1'b0;

	// Half-period divider, free running
	always_ff @(posedge clk_sys) begin
		if (!reset_n || tick) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// Device output is a pin from another domain
	always_ff @(posedge clk_sys) begin
		dout_m_q <= link.dout;
		dout_s_q <= dout_m_q;
	end

	// Pending read: a new request wins over the clear
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_pend_q <= 1'b0;
		end else if (rd_req) begin
			rd_pend_q <= 1'b1;
		end else if (state_q == H_SETUP && dir_q) begin
			rd_pend_q <= 1'b0;
		end
	end

	// Link sequencer
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_q  <= H_IDLE;
			sclk_q   <= 1'b0;
			frame_q  <= 1'b0;
			dir_q    <= 1'b0;
			sh_q     <= 8'h00;
			bit_q    <= 6'h00;
			rsh_q    <= 8'h00;
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end else begin
			rd_valid <= 1'b0;
			if (tick) begin
				unique case (state_q)
					H_IDLE: begin
						// Direction settles a half period before the frame
						bit_q <= 6'h00;
						if (rd_pend_q) begin
							dir_q   <= 1'b1;
							state_q <= H_SETUP;
						end else if (f_valid) begin
							dir_q   <= 1'b0;
							state_q <= H_SETUP;
						end
					end
					H_SETUP: begin
						frame_q <= 1'b1;
						sh_q    <= dir_q ? 8'h00 : f_data;
						state_q <= H_LOW;
					end
					H_LOW: begin
						// Read bit k-1 is stable after falling edge k
						if (dir_q && bit_q != 6'h00) begin
							rsh_q <= {rsh_q[6:0], dout_s_q};
							if (bit_q[2:0] == 3'h0) begin
								rd_valid <= 1'b1;
								rd_data  <= {rsh_q[6:0], dout_s_q};
							end
						end
						if (dir_q && bit_q == 6'(READ_BITS)) begin
							state_q <= H_CLOSE;
						end else begin
							sclk_q  <= 1'b1;
							state_q <= H_HIGH;
						end
					end
					H_HIGH: begin
						sclk_q  <= 1'b0;
						bit_q   <= bit_q + 6'h01;
						state_q <= H_LOW;
						if (!dir_q && bit_q[2:0] == LAST_BIT) begin
							// Whole words only; next word or finish
							if (more) begin
								sh_q <= f_data;
							end else begin
								state_q <= H_CLOSE;
							end
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
						end
					end
					H_CLOSE: begin
						frame_q <= 1'b0;
						state_q <= H_IDLE;
					end
					default: begin
						state_q <= H_IDLE;
					end
				endcase
			end
		end
	end

endmodule

// [shared/qwp_pkg.sv]
// Purpose: Shared constants for the quad wiper five-wire serial port
// Assumes: Both ends and the bench import this package
// Notes:   Counts in cycles are derived from times and the system clock
//
// Summary of operation
// - Wipers start at mid-scale 32 after reset
// - Six-bit position, 63 top, 0 bottom
// - Port works only while choice pin is low
// - Choice pin high selects the other port
// - Word is 2-bit channel plus 6-bit position
// - MSB first, whole multiples of eight bits
// - Frame rise starts transaction, active while high
// - Direction sampled at frame start, then ignored
// - Write: data bit taken on rising clock
// - Eighth falling edge loads the selected wiper
// - One to four words per write, any order
// - Frame fall ends transaction, port disabled
// - Cascade output held low while writing
// - Frame low passes input straight to output
// - Read: new bit after each falling edge
// - Read order channel 0 to 3, MSB first
package qwp_pkg;

	// Word layout
	localparam int POS_W   = 6;
	localparam int SEL_W   = 2;
	localparam int WORD_W  = SEL_W + POS_W;
	localparam int N_POTS  = 4;
	localparam int SEL_MSB = WORD_W - 1;
	localparam int POS_MSB = POS_W - 1;

	// Wiper codes
	localparam logic [POS_W-1:0] POS_MID = 6'h20;
	localparam logic [POS_W-1:0] POS_TOP = 6'h3F;
	localparam logic [POS_W-1:0] POS_BOT = 6'h00;

	// Transfer sizes
	localparam int WORDS_MAX = 4;
	localparam int READ_BITS = N_POTS * WORD_W;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Timing: system clock and read data settle time after falling edge
	localparam int CLK_SYS_NS    = 40;
	localparam int DOUT_VALID_NS = 20;
	localparam int SETTLE_CYC    =
		(DOUT_VALID_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	// Half period of the link clock in system cycles: settle plus sync
	localparam int SCLK_HALF = SETTLE_CYC + 3;

	// Host buffer depth
	localparam int FIFO_DEPTH = 8;

	typedef logic [POS_W-1:0]  qwp_pos_t;
	typedef logic [WORD_W-1:0] qwp_word_t;

endpackage

// [shared/qwp_if.sv]
// Purpose: Five-wire link between controller and wiper device
// Assumes: Controller makes the serial clock and all inputs
// Notes:   All lines are one-way; no two-way pins are needed
interface qwp_if;
	logic sclk;                 // Serial clock, made by controller
	logic frame;                // Transfer window, high while active
	logic din;                  // Serial data into the device
	logic dout;                 // Cascade data out of the device
	logic dir;                  // Direction, high reads
	logic interface_choice_pin; // Low selects this port

	modport dev (
		input  sclk,
		input  frame,
		input  din,
		input  dir,
		input  interface_choice_pin,
		output dout
	);

	modport host (
		output sclk,
		output frame,
		output din,
		output dir,
		output interface_choice_pin,
		input  dout
	);
endinterface

// [core/qwp_device.sv]
// Purpose: Device end: serial shift port and four wiper registers
// Assumes: Runs on the link clock and the frame edges; frame and data are launched by
//          the controller in the link clock's own timing
// Notes:   The frame signal clears the port state asynchronously, since
//          the link clock stands still between frames
module qwp_device (
	// Link to the controller
	qwp_if.dev                                  link,
	// Power-up reset, synchronous to the link clock
	input  wire logic                           reset_n,
	// Wiper positions towards the resistor ladders
	output logic [qwp_pkg::N_POTS-1:0][qwp_pkg::POS_W-1:0] wiper_pos
);
	import qwp_pkg::*;

	// Port state on the rising edge
	logic             dir_q;      // Direction held for the frame
	logic [6:0]       shift_q;    // Bits gathered so far
	logic [2:0]       bit_cnt_q;  // Position within the current word
	logic             full_q;     // Complete word waiting for commit
	qwp_word_t        word_q;     // Complete word

	// Read side on the falling edge
	logic [4:0]       rd_cnt_q;   // Bit index across all four words
	logic             dout_q;     // Registered read data bit

	// Wiper storage
	qwp_pos_t         wiper_q [N_POTS];

	// Derived terms
	logic             port_on;    // Frame open and this port chosen
	logic             dir_eff;    // Direction in force for this edge

	// Builds the read-back word for one channel
	function automatic qwp_word_t read_word(input logic [1:0] ch);
		qwp_word_t w;
		w = {ch, wiper_q[ch]};
		return w;
	endfunction

	// Picks one read bit, MSB first within each word
	function automatic logic read_bit(input logic [4:0] idx);
		qwp_word_t w;
		logic [2:0] pos;
		w   = read_word(idx[4:3]);
		pos = LAST_BIT - idx[2:0];
		return w[pos];
	endfunction

	// The five-wire port only listens while its choice pin is low;
	// when the pin is high the other port owns the device and this
	// logic stays idle
	assign port_on = link.frame & ~link.interface_choice_pin;

	// Direction in force is the one caught as the frame opened; the
	// live pin is not looked at again until the next frame
	assign dir_eff = dir_q;

	// Direction is caught by the frame's own rising edge, so a change
	// made before the first clock pulse is already ignored. No reset
	// is needed: the value is only used while the frame is high.
	always_ff @(posedge link.frame) begin
		dir_q <= link.dir;
	end

	// Write shifter: one bit per rising edge, MSB first
	always_ff @(posedge link.sclk or negedge link.frame) begin
		if (!link.frame) begin
			// A half word is simply forgotten here
			shift_q   <= 7'h00;
			bit_cnt_q <= 3'h0;
		end else if (!reset_n) begin
			shift_q   <= 7'h00;
			bit_cnt_q <= 3'h0;
		end else if (port_on && !dir_eff) begin
			shift_q   <= {shift_q[5:0], link.din};
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	// Word completion flag, raised on the eighth rising edge
	always_ff @(posedge link.sclk or negedge link.frame) begin
		if (!link.frame) begin
			full_q <= 1'b0;
			word_q <= '0;
		end else if (!reset_n) begin
			full_q <= 1'b0;
			word_q <= '0;
		end else if (port_on && !dir_eff && bit_cnt_q == LAST_BIT) begin
			full_q <= 1'b1;
			word_q <= {shift_q, link.din};
		end else begin
			// Flag lives for exactly one clock pulse
			full_q <= 1'b0;
		end
	end

	// Wiper registers load on the falling edge of the eighth pulse.
	// Only the addressed channel changes, so words may come in any
	// order and any count within the frame.
	always_ff @(negedge link.sclk) begin
		if (!reset_n) begin
			// Volatile storage starts mid-scale
			for (int i = 0; i < N_POTS; i++) begin
				wiper_q[i] <= POS_MID;
			end
		end else if (full_q && port_on) begin
			wiper_q[word_q[SEL_MSB:POS_W]] <= word_q[POS_MSB:0];
		end
	end

	// Read shifter: a new bit appears after each falling edge.
	// After the last bit of channel 3 the index wraps to channel 0.
	always_ff @(negedge link.sclk or negedge link.frame) begin
		if (!link.frame) begin
			rd_cnt_q <= 5'h00;
			dout_q   <= 1'b0;
		end else if (!reset_n) begin
			rd_cnt_q <= 5'h00;
			dout_q   <= 1'b0;
		end else if (port_on && dir_eff) begin
			dout_q   <= read_bit(rd_cnt_q);
			rd_cnt_q <= rd_cnt_q + 5'h01;
		end
	end

	// Cascade output select. The pass-through is a plain wire by
	// intent: a chain of devices must forward data with no delay.
	always_comb begin
		if (link.interface_choice_pin) begin
			// Other port in use; keep the cascade quiet
			link.dout = 1'b0;
		end else if (!link.frame) begin
			link.dout = link.din;
		end else if (!dir_eff) begin
			// Write: block forwarding of incoming data
			link.dout = 1'b0;
		end else begin
			link.dout = dout_q;
		end
	end

	// Positions towards the ladders; code 63 is the upper terminal
	// and code 0 the lower one, the ladder decodes the rest
	always_comb begin
		for (int i = 0; i < N_POTS; i++) begin
			wiper_pos[i] = wiper_q[i];
		end
	end

endmodule

// [test/qwp_asserts.sv]
// Purpose: Checks on the link between host and device
// Assumes: Host launches sclk, frame, din and dir from clk_sys flops; choice pin tied low
// Notes:   Fall count clears on frame low, as the link clock stops
module qwp_asserts (
	// Clocks and resets
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic link_reset_n,
	// Link lines
	input  wire logic sclk,
	input  wire logic frame,
	input  wire logic din,
	input  wire logic dout,
	input  wire logic dir,
	input  wire logic interface_choice_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       sclk_q; // Link clock one cycle back
	logic [5:0] rise_q; // Rises in this frame
	logic [5:0] fall_q; // Falls in this frame
	logic [5:0] idx;    // Read bit index from zero
	assign idx = fall_q - 6'h01;
	// Rises seen from clk_sys
	always_ff @(posedge clk_sys) begin
		sclk_q <= sclk;
		if (!frame)
			rise_q <= 6'h00;
		else if (sclk && !sclk_q)
			rise_q <= rise_q + 6'h01;
	end
	// Falls in the link domain; frame low clears
	always_ff @(negedge sclk or negedge frame) begin
		if (!frame)
			fall_q <= 6'h00;
		else
			fall_q <= fall_q + 6'h01;
	end
	property p_choice;
		@(posedge clk_sys) disable iff (!reset_n) !interface_choice_pin;
	endproperty
	a_choice: assert property (p_choice)
		else $error("choice pin high");
	property p_pass;
		@(posedge clk_sys) disable iff (!reset_n) !frame |-> dout == din;
	endproperty
	a_pass: assert property (p_pass)
		else $error("cascade not passing input");
	property p_inhib;
		@(posedge clk_sys) disable iff (!reset_n) frame && !dir |-> !dout;
	endproperty
	a_inhib: assert property (p_inhib)
		else $error("cascade not inhibited");
	property p_dir;
		@(posedge clk_sys) disable iff (!reset_n) frame |-> $stable(dir);
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction moved in frame");
	property p_idle;
		@(posedge clk_sys) disable iff (!reset_n) !frame |-> !sclk;
	endproperty
	a_idle: assert property (p_idle)
		else $error("link clock outside frame");
	property p_din;
		@(posedge clk_sys) disable iff (!reset_n)
		frame && sclk |-> $stable(din);
	endproperty
	a_din: assert property (p_din)
		else $error("data moved while clock high");
	property p_len;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(frame) && !$past(dir)
		|-> rise_q inside {6'h08, 6'h10, 6'h18, 6'h20};
	endproperty
	a_len: assert property (p_len)
		else $error("write frame not whole words");
	property p_rdbit;
		@(posedge sclk) disable iff (!link_reset_n)
		frame && dir && fall_q != 6'h00 && fall_q <= 6'h20
		&& idx[2:1] == 2'h0 |-> dout == (idx[0] ? idx[3] : idx[4]);
	endproperty
	a_rdbit: assert property (p_rdbit)
		else $error("read word channel bits wrong");
	property p_rdhold;
		@(posedge clk_sys) disable iff (!reset_n)
		frame && dir && sclk |-> $stable(dout);
	endproperty
	a_rdhold: assert property (p_rdhold)
		else $error("read bit moved while clock high");
endmodule

// [test/quad_wiper_five_wire_port_tb_top.sv]
// Purpose: Bench joining host and device ends
// Assumes: Host divides clk_sys down for the link clock
// Notes:   A second device is driven by hand to break link rules
module quad_wiper_five_wire_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import qwp_pkg::*;
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
	fails++; $display("Error %s expected %h seen %h", n, e, g); end end
	typedef logic [N_POTS-1:0][POS_W-1:0] qwp_pos4_t;
	logic      clk_sys   = 1'b0; // System clock
	logic      reset_n   = 1'b0; // Host reset
	logic      dev_rst_n = 1'b0; // Both device resets
	logic      wr_valid  = 1'b0; // Write word offered
	qwp_word_t wr_data   = 8'h00;
	logic      rd_req    = 1'b0; // Read all four
	logic      wr_ready, rd_valid, busy, sp, saw_full;
	qwp_word_t rd_data, er, lf;
	qwp_pos4_t wp, wp2, wp_p, wp2_p, ew, wp_m, wp2_m;
	qwp_word_t q_r[$];  // Read words to come
	qwp_pos4_t q_w[$];  // Wiper sets to come
	qwp_pos4_t q_w2[$]; // Same, hand-driven device
	int        fails     = 0;
	int        tests_run = 0;
	int        cyc       = 0;
	qwp_if link ();
	qwp_if link2 ();
	qwp_host i_qwp_host (.clk_sys(clk_sys), .reset_n(reset_n),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
		.busy(busy), .link(link.host));
	qwp_device i_qwp_device (.link(link.dev), .reset_n(dev_rst_n),
		.wiper_pos(wp));
	qwp_device i_qwp_device2 (.link(link2.dev), .reset_n(dev_rst_n),
		.wiper_pos(wp2));
	qwp_asserts i_qwp_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
		.link_reset_n(dev_rst_n), .sclk(link.sclk), .frame(link.frame),
		.din(link.din), .dout(link.dout), .dir(link.dir),
		.interface_choice_pin(link.interface_choice_pin));
	initial forever #20 clk_sys = ~clk_sys;
	// Pseudo-random words
	function automatic qwp_word_t nxt(qwp_word_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Offer a word, hold it until taken; note only real changes
	task automatic push(qwp_word_t w);
		wr_valid <= 1'b1;
		wr_data <= w;
		@(negedge clk_sys);
		while (!wr_ready) begin
			saw_full = 1'b1;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		if (wp_m[w[7:6]] !== w[5:0]) begin
			wp_m[w[7:6]] = w[5:0];
			q_w.push_back(wp_m);
		end
	endtask
	// Ask for all four words, noting what must come back
	task automatic rd();
		rd_req <= 1'b1;
		for (int c = 0; c < N_POTS; c++)
			q_r.push_back({2'(c), wp_m[c]});
		@(posedge clk_sys);
		rd_req <= 1'b0;
	endtask
	// Hand-driven frame of n bits; dir may move after the first rise
	task automatic send2(logic pin, int n, logic [31:0] bits, logic flip);
		link2.interface_choice_pin <= pin;
		link2.dir <= 1'b0;
		#15 link2.frame <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			link2.din <= bits[i];
			#15 link2.sclk <= 1'b1;
			#15 link2.sclk <= 1'b0;
			link2.dir <= flip;
		end
		#15 link2.frame <= 1'b0;
	endtask
	// Result watcher: each change or read word takes the oldest note
	always @(posedge clk_sys) begin
		wp_p <= wp;
		wp2_p <= wp2;
		sp <= link.sclk;
		if (dev_rst_n && wp !== wp_p) begin
			ew = q_w.size() ? q_w.pop_front() : 'x;
			`CHK("wiper", ew, wp)
			`CHK("load edge", 2'h2, {sp, link.sclk})
		end
		if (dev_rst_n && wp2 !== wp2_p) begin
			ew = q_w2.size() ? q_w2.pop_front() : 'x;
			`CHK("wiper two", ew, wp2)
		end
		if (rd_valid === 1'b1) begin
			er = q_r.size() ? q_r.pop_front() : 'x;
			`CHK("read word", er, rd_data)
			`CHK("busy in read", 1'b1, busy)
		end
	end
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		saw_full = 1'b0;
		lf = 8'h60;
		wp_m = {N_POTS{POS_MID}};
		wp2_m = wp_m;
		{link2.sclk, link2.frame, link2.din, link2.dir} = 4'h0;
		link2.interface_choice_pin = 1'b0;
		// Device reset is synchronous, so it needs link clock edges
		repeat (2) begin
			#15 link2.sclk = 1'b1;
			#15 link2.sclk = 1'b0;
		end
		repeat (6)
			@(posedge clk_sys);
		reset_n <= 1'b1;
		// One frame while device one is still held in reset
		wr_valid <= 1'b1;
		@(posedge clk_sys);
		wr_valid <= 1'b0;
		wait (link.frame);
		wait (!link.frame);
		@(posedge clk_sys);
		dev_rst_n <= 1'b1;
		@(posedge clk_sys);
		`CHK("reset wipers", {N_POTS{POS_MID}}, wp)
		rd();
		push({2'h3, POS_TOP});
		push({2'h0, POS_BOT});
		for (int i = 0; i < 12; i++) begin
			lf = nxt(lf);
			push(lf);
		end
		wr_valid <= 1'b0;
		`CHK("buffer refused", 1'b1, saw_full)
		while (q_w.size() || busy)
			@(posedge clk_sys);
		rd();
		while (q_r.size() || busy)
			@(posedge clk_sys);
		// Good, short, wrong-port and mixed-direction frames
		wp2_m[1] = 6'h15;
		q_w2.push_back(wp2_m);
		send2(1'b0, 8, 32'h55, 1'b0);
		send2(1'b0, 5, 32'h1F, 1'b0);
		send2(1'b1, 8, 32'hEA, 1'b0);
		wp2_m[3] = 6'h01;
		q_w2.push_back(wp2_m);
		wp2_m[0] = 6'h0A;
		q_w2.push_back(wp2_m);
		send2(1'b0, 16, 32'hC10A, 1'b1);
		link2.din <= 1'b1;
		#5 `CHK("cascade", 1'b1, link2.dout)
		repeat (3)
			@(posedge clk_sys);
		`CHK("notes left", 0, q_w.size() + q_w2.size() + q_r.size())
		close_out();
	end
endmodule
